// ### ehd_defs.vh
`ifndef EHD_DEFS_VH
`define EHD_DEFS_VH

// Register word offsets on the 4-bit address
`define EHD_REG_CTRL 4'h0
`define EHD_REG_LOADED 4'h1
`define EHD_REG_STATUS 4'h2
`define EHD_REG_CAUSE 4'h3
`define EHD_REG_FLAGS 4'h4
`define EHD_REG_PEND 4'h5
`define EHD_REG_STACK0 4'h8
`define EHD_REG_STACK1 4'h9
`define EHD_REG_STACK2 4'ha
`define EHD_REG_STACK3 4'hb
`define EHD_REG_STACK4 4'hc

// CTRL fields
`define EHD_CTRL_ADCHK_DIS 0
`define EHD_CTRL_RESTART 1
`define EHD_CTRL_RST 1'b0
`define EHD_LOADED_RST 18'h00000

// FLAGS fields
`define EHD_FLG_QOVF 0
`define EHD_FLG_MASKED 1
`define EHD_FLG_GEN 2
`define EHD_FLG_STKOVF 3

// STATUS fields
`define EHD_ST_MODE_LSB 0
`define EHD_ST_DEPTH_LSB 2
`define EHD_ST_BUSY 5
`define EHD_ST_LAST_LSB 8

// Run modes
`define EHD_MODE_RUN 2'h0
`define EHD_MODE_SSTOP 2'h1
`define EHD_MODE_HSTOP 2'h2

// Cause indices, lowest index wins when several are pending
`define EHD_C_LOGIC_BLK 4'h0
`define EHD_C_DATA_BLK 4'h1
`define EHD_C_TO_DIRECT 4'h2
`define EHD_C_TO_IMAGE 4'h3
`define EHD_C_ADDR 4'h4
`define EHD_C_CYCLE 4'h5
`define EHD_C_SUBST 4'h6
`define EHD_C_TO_PIBYTE 4'h7
`define EHD_C_TO_DIST 4'h8
`define EHD_C_PARITY 4'h9
`define EHD_C_LOADXFER 4'ha
`define EHD_C_QOVF 4'hb
`define EHD_C_MASKED 4'hc
`define EHD_C_GEN 4'hd
`define EHD_C_SELFTEST 4'he

// Causes that stop when their handler is absent
`define EHD_STOP_MASK 15'h2ef2

// Handler numbers
`define EHD_HB_BASE 6'h13
`define EHD_HB_MISSING 6'h13
`define EHD_HB_TO_DIRECT 6'h17
`define EHD_HB_TO_IMAGE 6'h18
`define EHD_HB_ADDR 6'h19
`define EHD_HB_CYCLE 6'h1a
`define EHD_HB_SUBST 6'h1b
`define EHD_HB_TO_PIBYTE 6'h1c
`define EHD_HB_TO_DIST 6'h1d
`define EHD_HB_PARITY 6'h1e
`define EHD_HB_LOADXFER 6'h20
`define EHD_HB_TIMED 6'h21
`define EHD_HB_GEN 6'h22
`define EHD_HB_SELFTEST 6'h24

// Cause codes for the shared handler
`define EHD_CODE_LOGIC_BLK 16'h0101
`define EHD_CODE_DATA_BLK 16'h0904
`define EHD_CODE_RST 16'h0000

`define EHD_STACK_MAX 3'h5

`endif

// ### ehd_pend.v
`timescale 1ns/10ps
module ehd_pend (
    input wire clk,
    input wire rstn,
    input wire set,
    input wire clr,
    output reg q
);

    // Set beats clear so an event in the clearing cycle survives
    always @(posedge clk) begin
        if (!rstn) begin
            q <= 1'b0;
        end else begin
            q <= set | (q & ~clr);
        end
    end

endmodule

// ### ehd_dispatch.v
`timescale 1ns/10ps
`include "ehd_defs.vh"

// How it works
// - Each detected error cause calls its assigned handler block; some causes share one.
// - Missing logic block calls handler 19; absent handler means resume.
// - Missing data block calls handler 19; absent handler means STOP.
// - Direct peripheral timeout calls handler 23; absent means continue.
// - Image update or flag transfer timeout calls 24; absent means continue.
// - Addressing error calls 25; absent stops only while checking enabled.
// - Cycle overrun calls 26, bad substitution 27; absent means STOP.
// - Interrupt input byte timeout calls 28; absent means STOP.
// - Distributed peripheral timeout calls 29; absent means continue.
// - Parity or user memory timeout calls 30; absent means STOP.
// - Load or transfer error calls 32; absent means STOP.
// - Timed collision calls 33; overflow stops, masked continues; own flags.
// - Generate error sets its flag, calls 34; absent means STOP.
// - Self-test failure calls 36; absent means continue.
// - New error during a handler nests at the next operation boundary.
// - Handlers return in the reverse of the order they were called.
// - At most five handlers nest; one more overflows and hard stops.
// - Stack depth 01 holds the newest interrupted level, deeper older.
// - Errors only break in at operation boundaries in RUN.
// - Errors during start-up stop it, enter STOP and call the handler.
// - Power failure and overflow hard stop, expansion not ready soft stops.
// - A readable cause code tells 0101H logic from 0904H data block.
module ehd_dispatch (
    input wire clk,
    input wire rstn,
    input wire [3:0] addr,
    input wire [31:0] wdata,
    input wire wr,
    input wire rd,
    output reg [31:0] rdata,
    input wire op_boundary,
    input wire startup,
    input wire [3:0] cur_level,
    input wire handler_return,
    input wire logic_block_missing,
    input wire data_block_missing,
    input wire timeout_error_direct_io,
    input wire timeout_error_image,
    input wire addressing_error,
    input wire cycle_time_exceeded,
    input wire substitution_error,
    input wire timeout_error_process_interrupt_input_byte,
    input wire timeout_error_distributed_io,
    input wire parity_error,
    input wire load_transfer_error,
    input wire timed_irq_queue_overflow,
    input wire timed_irq_masked_too_long,
    input wire data_block_generate_error,
    input wire self_test_error,
    input wire central_power_failure,
    input wire expansion_unit_not_ready,
    output reg handler_call,
    output reg [5:0] handler_num,
    output reg [3:0] handler_cause,
    output wire cpu_run,
    output wire soft_stop,
    output wire hard_stop
);

    wire [14:0] err_in;
    wire [14:0] pend;
    wire [3:0] flags;
    reg [14:0] take;
    reg [3:0] flag_set;
    reg [3:0] flag_clr;
    reg [1:0] mode;
    reg [1:0] next_mode;
    reg [2:0] depth;
    reg [3:0] stk [0:4];
    reg [17:0] loaded;
    reg addressing_check_disable;
    reg [15:0] cause_code;
    reg [3:0] last_cause;
    reg [3:0] sel;
    reg found;
    reg [5:0] hnum;
    reg [5:0] hidx;
    reg hit;
    reg stop_absent;
    reg disp;
    reg overflow;
    reg do_call;
    reg do_pop;
    reg restart;
    reg [14:0] stop_vec;
    integer i;
    integer j;
    genvar g;

    assign err_in = {
        self_test_error,
        data_block_generate_error,
        timed_irq_masked_too_long,
        timed_irq_queue_overflow,
        load_transfer_error,
        parity_error,
        timeout_error_distributed_io,
        timeout_error_process_interrupt_input_byte,
        substitution_error,
        cycle_time_exceeded,
        addressing_error,
        timeout_error_image,
        timeout_error_direct_io,
        data_block_missing,
        logic_block_missing
    };

    // One latch per cause keeps it pending until it is dispatched
    generate
        for (g = 0; g < 15; g = g + 1) begin : g_pend
            ehd_pend u_pend (
                .clk(clk),
                .rstn(rstn),
                .set(err_in[g]),
                .clr(take[g]),
                .q(pend[g])
            );
        end
        for (g = 0; g < 4; g = g + 1) begin : g_flag
            ehd_pend u_flag (
                .clk(clk),
                .rstn(rstn),
                .set(flag_set[g]),
                .clr(flag_clr[g]),
                .q(flags[g])
            );
        end
    endgenerate

    // Fixed priority: the lowest pending index goes first
    always @* begin
        sel = 4'h0;
        found = 1'b0;
        for (j = 14; j >= 0; j = j - 1) begin
            if (pend[j]) begin
                sel = j[3:0];
                found = 1'b1;
            end
        end
    end

    // Cause to handler mapping
    always @* begin
        case (sel)
            `EHD_C_LOGIC_BLK: hnum = `EHD_HB_MISSING;
            `EHD_C_DATA_BLK: hnum = `EHD_HB_MISSING;
            `EHD_C_TO_DIRECT: hnum = `EHD_HB_TO_DIRECT;
            `EHD_C_TO_IMAGE: hnum = `EHD_HB_TO_IMAGE;
            `EHD_C_ADDR: hnum = `EHD_HB_ADDR;
            `EHD_C_CYCLE: hnum = `EHD_HB_CYCLE;
            `EHD_C_SUBST: hnum = `EHD_HB_SUBST;
            `EHD_C_TO_PIBYTE: hnum = `EHD_HB_TO_PIBYTE;
            `EHD_C_TO_DIST: hnum = `EHD_HB_TO_DIST;
            `EHD_C_PARITY: hnum = `EHD_HB_PARITY;
            `EHD_C_LOADXFER: hnum = `EHD_HB_LOADXFER;
            `EHD_C_QOVF: hnum = `EHD_HB_TIMED;
            `EHD_C_MASKED: hnum = `EHD_HB_TIMED;
            `EHD_C_GEN: hnum = `EHD_HB_GEN;
            `EHD_C_SELFTEST: hnum = `EHD_HB_SELFTEST;
            default: hnum = `EHD_HB_SELFTEST;
        endcase
    end

    always @* begin
        hidx = hnum - `EHD_HB_BASE;
        hit = loaded[hidx[4:0]];
        // Addressing errors stop only while checking is enabled
        stop_vec = `EHD_STOP_MASK >> sel;
        stop_absent = stop_vec[0];
        if (sel == `EHD_C_ADDR && addressing_check_disable) begin
            stop_absent = 1'b0;
        end
        // A return and a new dispatch never share a cycle; the
        // pending cause simply waits one more boundary.
        disp = found && op_boundary && !handler_return
            && mode == `EHD_MODE_RUN
            && !central_power_failure;
        overflow = disp && hit && depth == `EHD_STACK_MAX;
        do_call = disp && hit && !overflow;
        do_pop = handler_return && depth != 3'h0;
        take = disp ? (15'h0001 << sel) : 15'h0000;
    end

    // Software strobes and hardware flag set events
    always @* begin
        restart = wr && addr == `EHD_REG_CTRL && wdata[`EHD_CTRL_RESTART];
        flag_clr = 4'h0;
        if (wr && addr == `EHD_REG_FLAGS) begin
            flag_clr = wdata[3:0];
        end
        flag_set = 4'h0;
        flag_set[`EHD_FLG_QOVF] = timed_irq_queue_overflow;
        flag_set[`EHD_FLG_MASKED] = timed_irq_masked_too_long;
        flag_set[`EHD_FLG_GEN] = data_block_generate_error;
        flag_set[`EHD_FLG_STKOVF] = overflow;
    end

    // Run mode
    always @* begin
        next_mode = mode;
        case (mode)
            `EHD_MODE_RUN: begin
                if (central_power_failure || overflow) begin
                    next_mode = `EHD_MODE_HSTOP;
                end else if (expansion_unit_not_ready) begin
                    next_mode = `EHD_MODE_SSTOP;
                end else if (disp && startup) begin
                    next_mode = `EHD_MODE_SSTOP;
                end else if (disp && !hit && stop_absent) begin
                    next_mode = `EHD_MODE_SSTOP;
                end
            end
            `EHD_MODE_SSTOP: begin
                if (central_power_failure) begin
                    next_mode = `EHD_MODE_HSTOP;
                end else if (restart && !expansion_unit_not_ready) begin
                    next_mode = `EHD_MODE_RUN;
                end
            end
            `EHD_MODE_HSTOP: begin
                // Only a reset leaves a hard stop
                next_mode = `EHD_MODE_HSTOP;
            end
            default: begin
                next_mode = `EHD_MODE_HSTOP;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rstn) begin
            mode <= `EHD_MODE_RUN;
        end else begin
            mode <= next_mode;
        end
    end

    assign cpu_run = mode == `EHD_MODE_RUN;
    assign soft_stop = mode == `EHD_MODE_SSTOP;
    assign hard_stop = mode == `EHD_MODE_HSTOP;

    // Level stack, entry 0 is depth 01
    always @(posedge clk) begin
        if (!rstn) begin
            depth <= 3'h0;
            for (i = 0; i < 5; i = i + 1) begin
                stk[i] <= 4'h0;
            end
        end else if (do_call) begin
            depth <= depth + 3'h1;
            stk[0] <= cur_level;
            for (i = 1; i < 5; i = i + 1) begin
                stk[i] <= stk[i - 1];
            end
        end else if (do_pop) begin
            // Newest handler returns first, reversing call order
            depth <= depth - 3'h1;
            for (i = 0; i < 4; i = i + 1) begin
                stk[i] <= stk[i + 1];
            end
            stk[4] <= 4'h0;
        end
    end

    // Handler call towards the core
    always @(posedge clk) begin
        if (!rstn) begin
            handler_call <= 1'b0;
            handler_num <= 6'h00;
            handler_cause <= 4'h0;
        end else begin
            handler_call <= do_call;
            if (do_call) begin
                handler_num <= hnum;
                handler_cause <= sel;
            end
        end
    end

    // Cause code and last dispatched cause
    always @(posedge clk) begin
        if (!rstn) begin
            cause_code <= `EHD_CODE_RST;
            last_cause <= 4'h0;
        end else if (disp) begin
            last_cause <= sel;
            if (sel == `EHD_C_LOGIC_BLK) begin
                cause_code <= `EHD_CODE_LOGIC_BLK;
            end else if (sel == `EHD_C_DATA_BLK) begin
                cause_code <= `EHD_CODE_DATA_BLK;
            end
        end
    end

    // Writable registers
    always @(posedge clk) begin
        if (!rstn) begin
            addressing_check_disable <= `EHD_CTRL_RST;
            loaded <= `EHD_LOADED_RST;
        end else if (wr) begin
            if (addr == `EHD_REG_CTRL) begin
                addressing_check_disable <= wdata[`EHD_CTRL_ADCHK_DIS];
            end
            if (addr == `EHD_REG_LOADED) begin
                loaded <= wdata[17:0];
            end
        end
    end

    // Read data stand for one cycle only; unmapped reads return zero
    always @(posedge clk) begin
        if (!rstn) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                `EHD_REG_CTRL: begin
                    rdata <= {31'h00000000, addressing_check_disable};
                end
                `EHD_REG_LOADED: begin
                    rdata <= {14'h0000, loaded};
                end
                `EHD_REG_STATUS: begin
                    rdata <= {20'h00000, last_cause, 2'h0,
                        depth != 3'h0, depth, mode};
                end
                `EHD_REG_CAUSE: begin
                    rdata <= {16'h0000, cause_code};
                end
                `EHD_REG_FLAGS: begin
                    rdata <= {28'h0000000, flags};
                end
                `EHD_REG_PEND: begin
                    rdata <= {17'h00000, pend};
                end
                `EHD_REG_STACK0: rdata <= {28'h0000000, stk[0]};
                `EHD_REG_STACK1: rdata <= {28'h0000000, stk[1]};
                `EHD_REG_STACK2: rdata <= {28'h0000000, stk[2]};
                `EHD_REG_STACK3: rdata <= {28'h0000000, stk[3]};
                `EHD_REG_STACK4: rdata <= {28'h0000000, stk[4]};
                default: rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

endmodule

// ### ehd_dispatch_props.sv
`timescale 1ns/10ps
module ehd_props (
    input wire clk,
    input wire rstn,
    input wire op_boundary,
    input wire startup,
    input wire handler_return,
    input wire central_power_failure,
    input wire expansion_unit_not_ready,
    input wire handler_call,
    input wire [5:0] handler_num,
    input wire [3:0] handler_cause,
    input wire cpu_run,
    input wire soft_stop,
    input wire hard_stop
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // Both timed collision causes share one handler
    function automatic logic [5:0] num_of(input logic [3:0] c);
        return (c < 4'h2) ? 6'h13 : (c < 4'ha) ? 6'h15 + c :
            (c == 4'ha) ? 6'h20 : (c < 4'hd) ? 6'h21 : (c == 4'hd) ? 6'h22 : 6'h24;
    endfunction

    sequence s_start_take;
        startup && cpu_run ##1 handler_call;
    endsequence

    property p_handler_map;
        handler_call |-> handler_num == num_of(handler_cause);
    endproperty
    property p_boundary;
        handler_call |-> $past(op_boundary) && $past(cpu_run);
    endproperty
    property p_no_call_on_return;
        handler_call |-> !$past(handler_return);
    endproperty
    property p_power;
        central_power_failure |=> hard_stop;
    endproperty
    property p_hard_hold;
        hard_stop |=> hard_stop;
    endproperty
    property p_one_mode;
        $onehot({cpu_run, soft_stop, hard_stop});
    endproperty
    property p_expansion;
        expansion_unit_not_ready && cpu_run |=> !cpu_run;
    endproperty
    property p_startup;
        s_start_take |-> soft_stop;
    endproperty
    property p_hard_quiet;
        hard_stop |-> !handler_call;
    endproperty

    a_handler_map: assert property (p_handler_map) else $error("wrong handler number");
    a_boundary: assert property (p_boundary) else $error("call off boundary");
    a_no_call_on_return: assert property (p_no_call_on_return) else $error("call on return");
    a_power: assert property (p_power) else $error("no hard stop on power loss");
    a_hard_hold: assert property (p_hard_hold) else $error("hard stop left");
    a_one_mode: assert property (p_one_mode) else $error("mode outputs not one-hot");
    a_expansion: assert property (p_expansion) else $error("expansion fault kept run");
    a_startup: assert property (p_startup) else $error("start-up call without stop");
    a_hard_quiet: assert property (p_hard_quiet) else $error("call in hard stop");
endmodule

bind ehd_dispatch ehd_props i_props (.*);

// ### error_handler_dispatch_test.sv
`timescale 1ns/10ps
`include "ehd_defs.vh"
`define CHK(g, e) check(g, e)
module error_handler_dispatch_test;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic op_boundary = 1'b1;
    logic startup = 1'b0;
    logic [3:0] cur_level = 4'h0;
    logic handler_return = 1'b0;
    logic [14:0] ev = 15'h0;
    logic cpf = 1'b0;
    logic eunr = 1'b0;
    logic rd_d = 1'b0;
    logic [3:0] lv;
    logic [31:0] r;
    wire [31:0] rdata;
    wire handler_call;
    wire [5:0] handler_num;
    wire [3:0] handler_cause;
    wire cpu_run;
    wire soft_stop;
    wire hard_stop;
    logic [31:0] exp_q[$];
    int error_cnt = 0;
    int total_checks = 0;
    localparam logic [14:0] stops = 15'h2ef2;
    logic [5:0] hb_num [0:14] = '{6'h13, 6'h13, 6'h17, 6'h18, 6'h19, 6'h1a, 6'h1b, 6'h1c,
        6'h1d, 6'h1e, 6'h20, 6'h21, 6'h21, 6'h22, 6'h24};

    ehd_dispatch i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .op_boundary(op_boundary), .startup(startup),
        .cur_level(cur_level), .handler_return(handler_return),
        .logic_block_missing(ev[0]), .data_block_missing(ev[1]),
        .timeout_error_direct_io(ev[2]), .timeout_error_image(ev[3]),
        .addressing_error(ev[4]), .cycle_time_exceeded(ev[5]),
        .substitution_error(ev[6]), .timeout_error_process_interrupt_input_byte(ev[7]),
        .timeout_error_distributed_io(ev[8]), .parity_error(ev[9]),
        .load_transfer_error(ev[10]), .timed_irq_queue_overflow(ev[11]),
        .timed_irq_masked_too_long(ev[12]), .data_block_generate_error(ev[13]),
        .self_test_error(ev[14]), .central_power_failure(cpf),
        .expansion_unit_not_ready(eunr), .handler_call(handler_call),
        .handler_num(handler_num), .handler_cause(handler_cause), .cpu_run(cpu_run),
        .soft_stop(soft_stop), .hard_stop(hard_stop));

    always #12.5 clk = ~clk;

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic do_reset;
        rstn <= 1'b0;
        tick(16);
        rstn <= 1'b1;
    endtask

    task automatic wreg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
    endtask

    // Read notes go into the same queue as calls, so reads and calls must arrive in the order they were queued
    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(1);
    endtask

    task automatic fire(input logic [14:0] m);
        ev <= m;
        tick(1);
        ev <= 15'h0;
    endtask

    task automatic expect_call(input int c);
        exp_q.push_back({20'h0, 2'b10, hb_num[c], 4'(c)});
    endtask

    task automatic ret;
        handler_return <= 1'b1;
        tick(1);
        handler_return <= 1'b0;
        tick(2);
    endtask

    always @(posedge clk) begin
        if (rd_d)
            `CHK(rdata, exp_q.pop_front());
        else if (rstn)
            `CHK(rdata, 32'h0);
        if (handler_call)
            `CHK({20'h0, 2'b10, handler_num, handler_cause}, exp_q.pop_front());
        rd_d <= rd;
    end

    initial begin
        tick(20000);
        error_cnt++;
        $display("watchdog expired");
        results();
    end

    initial begin
        void'($urandom(64755));
        do_reset();
        rreg(`EHD_REG_STATUS, 32'h0);
        rreg(`EHD_REG_CAUSE, 32'h0);
        rreg(4'hf, 32'h0);
        r = $urandom();
        wreg(`EHD_REG_LOADED, r);
        rreg(`EHD_REG_LOADED, r & 32'h3ffff);
        $display("test registers done");

        wreg(`EHD_REG_LOADED, 32'h3ffff);
        for (int c = 0; c < 15; c++) begin
            lv = 4'($urandom());
            cur_level <= lv;
            expect_call(c);
            fire(15'h1 << c);
            tick(3);
            rreg(`EHD_REG_STACK0, {28'h0, lv});
            if (c < 2)
                rreg(`EHD_REG_CAUSE, c ? 32'h0904 : 32'h0101);
            ret();
        end
        rreg(`EHD_REG_FLAGS, 32'h7);
        wreg(`EHD_REG_FLAGS, 32'h5);
        rreg(`EHD_REG_FLAGS, 32'h2);
        $display("test loaded handlers done");

        do_reset();
        for (int c = 0; c < 15; c++) begin
            fire(15'h1 << c);
            tick(3);
            rreg(`EHD_REG_STATUS, {20'h0, 4'(c), 7'h0, stops[c]});
            if (stops[c])
                wreg(`EHD_REG_CTRL, 32'h2);
        end
        wreg(`EHD_REG_CTRL, 32'h1);
        fire(15'h10);
        tick(3);
        rreg(`EHD_REG_STATUS, 32'h400);
        $display("test absent handlers done");

        do_reset();
        wreg(`EHD_REG_LOADED, 32'h3ffff);
        cur_level <= 4'h1;
        expect_call(0);
        expect_call(9);
        expect_call(14);
        fire(15'h4201);
        tick(5);
        for (int k = 2; k < 5; k++) begin
            cur_level <= 4'(k);
            if (k < 4)
                expect_call(9);
            fire(15'h200);
            tick(3);
        end
        for (int i = 0; i < 5; i++)
            rreg(`EHD_REG_STACK0 + 4'(i), (i == 0) ? 32'h3 : (i == 1) ? 32'h2 : 32'h1);
        rreg(`EHD_REG_FLAGS, 32'h8);
        `CHK({31'h0, hard_stop}, 32'h1);
        $display("test nesting done");

        do_reset();
        wreg(`EHD_REG_LOADED, 32'h3ffff);
        // Hold the core mid-operation: the event must wait, not vanish
        op_boundary <= 1'b0;
        fire(15'h4);
        tick(6);
        expect_call(2);
        op_boundary <= 1'b1;
        tick(3);
        ret();
        startup <= 1'b1;
        expect_call(5);
        fire(15'h20);
        tick(3);
        `CHK({31'h0, soft_stop}, 32'h1);
        startup <= 1'b0;
        fire(15'h4);
        tick(2);
        rreg(`EHD_REG_PEND, 32'h4);
        expect_call(2);
        wreg(`EHD_REG_CTRL, 32'h2);
        tick(3);
        $display("test boundary and start-up done");

        do_reset();
        eunr <= 1'b1;
        tick(2);
        wreg(`EHD_REG_CTRL, 32'h2);
        tick(1);
        `CHK({31'h0, soft_stop}, 32'h1);
        eunr <= 1'b0;
        wreg(`EHD_REG_CTRL, 32'h2);
        tick(1);
        `CHK({31'h0, cpu_run}, 32'h1);
        cpf <= 1'b1;
        tick(1);
        cpf <= 1'b0;
        tick(3);
        `CHK({31'h0, hard_stop}, 32'h1);
        $display("test immediate stops done");

        if (exp_q.size() != 0) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, 32'h0, exp_q.size());
        end
        results();
    end
endmodule
